// file: oss_pkg.sv
// shared constants and carrier types for the sensor sequencer and bus target
package oss_pkg;
    localparam logic [6:0] OSS_TARGET_ADDR = 7'h39;
    localparam int         OSS_CLK_PERIOD_NS = 4;
    localparam real        OSS_WAIT_STEP_MS = 2.78;
    localparam int         OSS_WAIT_STEP_CYCLES =
        int'(OSS_WAIT_STEP_MS * 1000000.0 / OSS_CLK_PERIOD_NS);
    localparam int         OSS_EXIT_SLEEP_NS = 10000;
    localparam int         OSS_EXIT_SLEEP_CYCLES =
        (OSS_EXIT_SLEEP_NS + OSS_CLK_PERIOD_NS - 1) / OSS_CLK_PERIOD_NS;
    localparam logic [8:0] OSS_WAIT_STEPS_FULL = 9'h100;
    localparam logic [3:0] OSS_LONG_WAIT_FACTOR = 4'hc;
    localparam int         OSS_CMD_FLAG_BIT = 7;
    localparam int         OSS_CMD_TYPE_HI = 6;
    localparam int         OSS_CMD_TYPE_LO = 5;
    localparam logic [1:0] OSS_CMD_SPECIAL = 2'h3;
    localparam int         OSS_ADDR_W = 5;
    localparam logic [3:0] OSS_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] OSS_LAST_TX_BIT = 4'h7;

    typedef struct packed {
        logic       power_on;
        logic       prox_enable;
        logic       gesture_engine_enable;
        logic       gesture_mode_bit;
        logic       als_enable;
        logic       wait_enable;
        logic       long_wait_bit;
        logic       sleep_after_interrupt;
        logic [7:0] wait_time_setting;
    } oss_cfg_t;

    typedef struct packed {
        logic prox;
        logic gest;
        logic als;
    } oss_eng_t;
endpackage

// file: oss_sequencer.sv
// bus target and operating state sequencer of the optical sensor core
//
// Contract
// [R01] answer only target address 0x39, seven-bit addressing, standard or fast
// [R02] write transfer: command byte follows address, then data bytes stored
// [R03] combined transfer: command write, repeated start, then byte reads
// [R04] read without command starts at address held from previous command
// [R05] byte with clear top bit is data at last saved address
// [R06] command byte is control command or five-bit address; control clears irq
// [R07] after reset go straight to sleep, oscillator stopped
// [R08] bus transaction during sleep wakes oscillator until it completes
// [R09] power-on bit starts oscillator; engines draw power only when entered
// [R10] first sleep exit with engines enabled inserts pause, then enters engine
// [R11] order: idle, proximity, gesture if mode set, wait, light, maybe sleep
// [R12] each engine state skipped or included by its own enable
// [R13] wait lasts 2.78 ms to 8.54 s from wait time and long-wait bit
// [R14] only proximity and gesture drive the led pin
// [R15] after enabled engines ran, return to idle or sleep per sleep bit
// [R16] sleep entered only when sleep bit set and interrupt pin asserted
// [R17] entering sleep changes no setting; power-on stays set
// [R18] leave that sleep on bus interrupt clear or sleep bit cleared
// [R19] transfers to other addresses unacknowledged and ignored
`timescale 1ns/10ps
module oss_sequencer #(
    parameter int WAIT_STEP_CYCLES = oss_pkg::OSS_WAIT_STEP_CYCLES
) (
    input  wire logic                             clock,
    input  wire logic                             rst,
    input  wire logic                             scl_in,
    input  wire logic                             sda_in,
    output logic                                  sda_out,
    output logic                                  sda_drive_n,
    input  wire oss_pkg::oss_cfg_t                cfg,
    input  wire logic                             int_pin_asserted,
    input  wire oss_pkg::oss_eng_t                engine_done,
    input  wire logic                             led_request,
    output oss_pkg::oss_eng_t                     engine_run,
    output logic                                  led_drive_pin,
    output logic                                  osc_enable,
    output logic                                  exit_pause,
    output logic                                  sai_sleeping,
    output logic                                  wr_strobe,
    output logic [oss_pkg::OSS_ADDR_W-1:0]        wr_addr,
    output logic [7:0]                            wr_data,
    output logic [oss_pkg::OSS_ADDR_W-1:0]        rd_addr,
    input  wire logic [7:0]                       rd_data,
    output logic                                  int_clear
);
    import oss_pkg::*;

    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_WDAT, I_WACK, I_RDAT, I_RACK
    } oss_bus_t;
    typedef enum logic [2:0] {
        S_SLEEP, S_PAUSE, S_IDLE, S_PROX, S_GEST, S_WAIT, S_ALS
    } oss_seq_t;

    // line synchronisers
    logic scl_meta, scl_sync, scl_prev;
    logic sda_meta, sda_sync, sda_prev;
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            scl_prev <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            scl_prev <= scl_sync;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_sync & ~scl_prev;
    assign scl_fall  = ~scl_sync & scl_prev;
    assign bus_start = scl_sync & scl_prev & sda_prev & ~sda_sync;
    assign bus_stop  = scl_sync & scl_prev & ~sda_prev & sda_sync;

    // bus target state
    oss_bus_t                ist_reg, ist_next;
    logic [3:0]              cnt_reg, cnt_next;
    logic [7:0]              shift_reg, shift_next;
    logic                    rw_reg, rw_next;
    logic                    first_reg, first_next;
    logic                    drive_reg, drive_next;
    logic [OSS_ADDR_W-1:0]   ptr_reg, ptr_next;
    logic [OSS_ADDR_W-1:0]   saved_reg, saved_next;
    logic                    wrs_reg, wrs_next;
    logic [OSS_ADDR_W-1:0]   wra_reg, wra_next;
    logic [7:0]              wrd_reg, wrd_next;
    logic                    clr_reg, clr_next;

    always_comb begin
        ist_next   = ist_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        rw_next    = rw_reg;
        first_next = first_reg;
        drive_next = drive_reg;
        ptr_next   = ptr_reg;
        saved_next = saved_reg;
        wrs_next   = 1'b0;
        wra_next   = wra_reg;
        wrd_next   = wrd_reg;
        clr_next   = 1'b0;
        if (bus_start) begin
            // also a repeated start inside a combined transfer
            ist_next   = I_ADDR; // [R03]
            cnt_next   = 4'h0;
            drive_next = 1'b0;
            first_next = 1'b1;
        end else if (bus_stop) begin
            ist_next   = I_IDLE;
            drive_next = 1'b0;
        end else begin
            case (ist_reg)
                I_ADDR, I_WDAT: begin
                    if (scl_rise) begin
                        shift_next = {shift_reg[6:0], sda_sync};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == OSS_BITS_PER_BYTE) begin
                        if (ist_reg == I_ADDR) begin
                            if (shift_reg[7:1] == OSS_TARGET_ADDR) begin // [R01]
                                drive_next = 1'b1;
                                rw_next    = shift_reg[0];
                                ptr_next   = saved_reg; // [R04]
                                ist_next   = I_AACK;
                            end else begin
                                ist_next = I_IDLE; // [R19]
                            end
                        end else begin
                            drive_next = 1'b1;
                            ist_next   = I_WACK;
                            first_next = 1'b0;
                            if (first_reg && shift_reg[OSS_CMD_FLAG_BIT]) begin
                                // command byte right after the address
                                if (shift_reg[OSS_CMD_TYPE_HI:OSS_CMD_TYPE_LO]
                                    == OSS_CMD_SPECIAL) begin
                                    clr_next = 1'b1; // [R06]
                                end else begin
                                    saved_next = shift_reg[OSS_ADDR_W-1:0]; // [R06]
                                    ptr_next   = shift_reg[OSS_ADDR_W-1:0]; // [R02]
                                end
                            end else begin
                                wrs_next = 1'b1; // [R05]
                                wra_next = ptr_reg; // [R02]
                                wrd_next = shift_reg;
                                ptr_next = ptr_reg + 1'b1;
                            end
                        end
                    end
                end
                I_AACK: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (rw_reg) begin
                            shift_next = rd_data;
                            drive_next = ~rd_data[7];
                            ist_next   = I_RDAT;
                        end else begin
                            drive_next = 1'b0;
                            ist_next   = I_WDAT;
                        end
                    end
                end
                I_WACK: begin
                    if (scl_fall) begin
                        drive_next = 1'b0;
                        cnt_next   = 4'h0;
                        ist_next   = I_WDAT;
                    end
                end
                I_RDAT: begin
                    if (scl_fall) begin
                        if (cnt_reg == OSS_LAST_TX_BIT) begin
                            drive_next = 1'b0;
                            ptr_next   = ptr_reg + 1'b1;
                            ist_next   = I_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            drive_next = ~shift_reg[6];
                            cnt_next   = cnt_reg + 4'h1;
                        end
                    end
                end
                I_RACK: begin
                    if (scl_rise && sda_sync) begin
                        ist_next = I_IDLE;
                    end else if (scl_fall) begin
                        shift_next = rd_data;
                        drive_next = ~rd_data[7];
                        cnt_next   = 4'h0;
                        ist_next   = I_RDAT;
                    end
                end
                default: begin
                    ist_next = I_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ist_reg   <= I_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            rw_reg    <= 1'b0;
            first_reg <= 1'b0;
            drive_reg <= 1'b0;
            ptr_reg   <= '0;
            saved_reg <= '0;
            wrs_reg   <= 1'b0;
            wra_reg   <= '0;
            wrd_reg   <= 8'h00;
            clr_reg   <= 1'b0;
        end else begin
            ist_reg   <= ist_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            rw_reg    <= rw_next;
            first_reg <= first_next;
            drive_reg <= drive_next;
            ptr_reg   <= ptr_next;
            saved_reg <= saved_next;
            wrs_reg   <= wrs_next;
            wra_reg   <= wra_next;
            wrd_reg   <= wrd_next;
            clr_reg   <= clr_next;
        end
    end

    assign sda_out     = 1'b0;
    assign sda_drive_n = ~drive_reg;
    assign wr_strobe   = wrs_reg;
    assign wr_addr     = wra_reg;
    assign wr_data     = wrd_reg;
    assign rd_addr     = ptr_reg;
    assign int_clear   = clr_reg;

    // next enabled stage after the given one, else end of cycle
    function automatic oss_seq_t oss_after(input oss_seq_t s,
                                           input oss_cfg_t c,
                                           input logic     irq);
        oss_seq_t   r;
        logic [2:0] pos;
        pos = 3'h0;
        case (s)
            S_PROX:  pos = 3'h1;
            S_GEST:  pos = 3'h2;
            S_WAIT:  pos = 3'h3;
            S_ALS:   pos = 3'h4;
            default: pos = 3'h0;
        endcase
        r = (c.sleep_after_interrupt && irq) ? S_SLEEP : S_IDLE; // [R15] [R16]
        if (pos <= 3'h3 && c.als_enable) r = S_ALS; // [R12]
        if (pos <= 3'h2 && c.wait_enable) r = S_WAIT; // [R12]
        if (pos <= 3'h1 && c.gesture_engine_enable && c.gesture_mode_bit)
            r = S_GEST; // [R11]
        if (pos == 3'h0 && c.prox_enable) r = S_PROX; // [R11]
        return r;
    endfunction

    logic any_engine;
    assign any_engine = cfg.prox_enable | cfg.gesture_engine_enable
                      | cfg.als_enable;

    // sequencer state
    oss_seq_t    seq_reg, seq_next;
    logic        once_reg, once_next;
    logic        hold_reg, hold_next;
    logic [19:0] tick_reg, tick_next;
    logic [11:0] steps_reg, steps_next;
    oss_eng_t    run_reg, run_next;
    logic        led_reg, led_next;
    logic        osc_reg, osc_next;

    always_comb begin
        seq_next   = seq_reg;
        once_next  = once_reg;
        hold_next  = hold_reg;
        tick_next  = tick_reg;
        steps_next = steps_reg;
        if (clr_reg || !cfg.sleep_after_interrupt) hold_next = 1'b0; // [R18]
        if (!cfg.power_on) begin
            seq_next  = S_SLEEP; // [R09]
            once_next = 1'b0;
        end else begin
            case (seq_reg)
                S_SLEEP: begin
                    if (!hold_next) begin // [R17]
                        if (any_engine && !once_reg) begin
                            seq_next  = S_PAUSE; // [R10]
                            once_next = 1'b1;
                            tick_next = 20'(OSS_EXIT_SLEEP_CYCLES - 1);
                        end else begin
                            seq_next = S_IDLE;
                        end
                    end
                end
                S_PAUSE: begin
                    if (tick_reg == 20'h0_0000) begin
                        seq_next = oss_after(S_IDLE, cfg, 1'b0); // [R10]
                    end else begin
                        tick_next = tick_reg - 20'h0_0001;
                    end
                end
                S_IDLE: begin
                    if (any_engine || cfg.wait_enable)
                        seq_next = oss_after(S_IDLE, cfg, 1'b0); // [R11]
                end
                S_PROX, S_GEST, S_ALS: begin
                    if ((seq_reg == S_PROX && engine_done.prox)
                     || (seq_reg == S_GEST && engine_done.gest)
                     || (seq_reg == S_ALS && engine_done.als))
                        seq_next = oss_after(seq_reg, cfg, int_pin_asserted);
                end
                S_WAIT: begin
                    if (tick_reg != 20'h0_0000) begin
                        tick_next = tick_reg - 20'h0_0001;
                    end else if (steps_reg != 12'h000) begin
                        steps_next = steps_reg - 12'h001; // [R13]
                        tick_next  = 20'(WAIT_STEP_CYCLES - 1);
                    end else begin
                        seq_next = oss_after(S_WAIT, cfg, int_pin_asserted);
                    end
                end
                default: begin
                    seq_next = S_SLEEP;
                end
            endcase
            if (seq_next == S_WAIT && seq_reg != S_WAIT) begin
                // steps are 256 minus setting, twelve-fold when long
                steps_next = 12'(OSS_WAIT_STEPS_FULL - cfg.wait_time_setting)
                           * (cfg.long_wait_bit ? 12'(OSS_LONG_WAIT_FACTOR)
                                                : 12'h001)
                           - 12'h001; // [R13]
                tick_next  = 20'(WAIT_STEP_CYCLES - 1);
            end
            if (seq_next == S_SLEEP && seq_reg != S_SLEEP)
                hold_next = 1'b1; // [R16]
        end
        run_next.prox = (seq_next == S_PROX);
        run_next.gest = (seq_next == S_GEST);
        run_next.als  = (seq_next == S_ALS);
        led_next = led_request && (seq_reg == S_PROX || seq_reg == S_GEST); // [R14]
        osc_next = (seq_next != S_SLEEP) || (ist_next != I_IDLE); // [R07] [R08]
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            seq_reg   <= S_SLEEP; // [R07]
            once_reg  <= 1'b0;
            hold_reg  <= 1'b0;
            tick_reg  <= 20'h0_0000;
            steps_reg <= 12'h000;
            run_reg   <= '0;
            led_reg   <= 1'b0;
            osc_reg   <= 1'b0;
        end else begin
            seq_reg   <= seq_next;
            once_reg  <= once_next;
            hold_reg  <= hold_next;
            tick_reg  <= tick_next;
            steps_reg <= steps_next;
            run_reg   <= run_next;
            led_reg   <= led_next;
            osc_reg   <= osc_next;
        end
    end

    assign engine_run    = run_reg;
    assign led_drive_pin = led_reg;
    assign osc_enable    = osc_reg;
    assign exit_pause    = (seq_reg == S_PAUSE);
    assign sai_sleeping  = hold_reg & (seq_reg == S_SLEEP);
endmodule

// file: oss_props.sv
// checker for the sequencer and bus target ports
`timescale 1ns/10ps
module oss_props #(
    parameter int WAIT_STEP_CYCLES = 4
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              scl_in,
    input wire logic              sda_drive_n,
    input wire oss_pkg::oss_cfg_t cfg,
    input wire logic              int_pin_asserted,
    input wire logic              led_request,
    input wire oss_pkg::oss_eng_t engine_run,
    input wire logic              led_drive_pin,
    input wire logic              osc_enable,
    input wire logic              exit_pause,
    input wire logic              sai_sleeping,
    input wire logic              int_clear
);
    import oss_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    reset_sleep_a: assert property ($fell(rst) |->
        !osc_enable && engine_run == '0 && sda_drive_n)
        else $error("not asleep after reset");
    run_one_hot_a: assert property ($onehot0(engine_run))
        else $error("two engines at once");
    power_off_a: assert property (!cfg.power_on [*3] |->
        engine_run == '0) else $error("engine runs with power off");
    ack_awake_a: assert property (!sda_drive_n |-> osc_enable)
        else $error("bus answer while oscillator off");
    ack_in_low_a: assert property ($fell(sda_drive_n) |-> !scl_in)
        else $error("data driven while bus clock high");
    gest_mode_a: assert property ($rose(engine_run.gest) |->
        $past(cfg.gesture_engine_enable && cfg.gesture_mode_bit))
        else $error("gesture entered without mode");
    led_cause_a: assert property (led_drive_pin |->
        $past(led_request) && !$past(engine_run.als))
        else $error("led driven without cause");
    pause_cause_a: assert property ($rose(exit_pause) |->
        $past(cfg.prox_enable | cfg.gesture_engine_enable | cfg.als_enable))
        else $error("pause without enabled engine");
    sai_enter_a: assert property ($rose(sai_sleeping) |->
        $past(cfg.sleep_after_interrupt && int_pin_asserted))
        else $error("sleep entered without cause");
    sai_leave_a: assert property (sai_sleeping &&
        !cfg.sleep_after_interrupt |-> ##[1:3] !sai_sleeping)
        else $error("sleep held after bit cleared");
    clear_pulse_a: assert property (int_clear |=> !int_clear)
        else $error("interrupt clear longer than a cycle");
    cover property (exit_pause ##1 !exit_pause);
    cover property ($rose(engine_run.gest));
    cover property ($rose(sai_sleeping));
endmodule
bind oss_sequencer oss_props #(.WAIT_STEP_CYCLES(WAIT_STEP_CYCLES))
    oss_props_inst (.clock(clock), .rst(rst), .scl_in(scl_in),
    .sda_drive_n(sda_drive_n), .cfg(cfg),
    .int_pin_asserted(int_pin_asserted), .led_request(led_request),
    .engine_run(engine_run), .led_drive_pin(led_drive_pin),
    .osc_enable(osc_enable), .exit_pause(exit_pause),
    .sai_sleeping(sai_sleeping), .int_clear(int_clear));

// file: oss_i2c_host.sv
// bus host model: link clock stands high outside frames
`timescale 1ns/10ps
module oss_i2c_host (
    input wire logic  clock,
    output logic      scl,
    output logic      sda_host,
    input wire logic  sda_wire
);
    initial begin
        scl = 1'b1;
        sda_host = 1'b1;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge clock);
    endtask
    // data bits change only after the clock low has lasted two cycles; start and stop move data with the clock high
    task automatic start();
        ticks(2);
        sda_host = 1'b1;
        ticks(6);
        scl = 1'b1;
        ticks(8);
        sda_host = 1'b0;
        ticks(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        ticks(2);
        sda_host = 1'b0;
        ticks(6);
        scl = 1'b1;
        ticks(8);
        sda_host = 1'b1;
        ticks(8);
    endtask
    task automatic bit_io(input logic b, output logic r);
        ticks(2);
        sda_host = b;
        ticks(6);
        scl = 1'b1;
        ticks(4);
        r = sda_wire;
        ticks(4);
        scl = 1'b0;
    endtask
    // msb first; ack slot sends a and returns the wire level
    task automatic xfer(input logic [7:0] d, input logic a,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(a, ack);
    endtask
endmodule

// file: tb.sv
// self-checking bench for the sequencer and bus target
`timescale 1ns/10ps
module tb;
    import oss_pkg::*;
    localparam int STEP = 4;
    logic             clock;
    logic             rst;
    logic             scl;
    logic             sda_host;
    logic             sda_wire;
    logic             sda_out;
    logic             sda_drive_n;
    oss_cfg_t         cfg;
    logic             int_pin;
    oss_eng_t         engine_done;
    logic             led_request;
    oss_eng_t         engine_run;
    oss_eng_t         last_run;
    logic             led_drive_pin;
    logic             osc_enable;
    logic             exit_pause;
    logic             sai_sleeping;
    logic             wr_strobe;
    logic [4:0]       wr_addr;
    logic [7:0]       wr_data;
    logic [4:0]       rd_addr;
    logic [7:0]       rd_data;
    logic             int_clear;
    logic [12:0]      wr_q[$];
    logic [2:0]       seq_q[$];
    int               errors = 0;
    int               check_count = 0;
    int               clr_cnt = 0;
    int               led_cnt = 0;
    int               gap = 0;
    int               als_gap = 0;
    int               run_cnt = 0;
    logic             pause_seen = 1'b0;
    oss_eng_t         prev_run = '0;

    assign sda_wire = sda_host & (sda_drive_n | sda_out);
    assign rd_data = {3'h2, rd_addr};

    oss_sequencer #(.WAIT_STEP_CYCLES(STEP)) oss_sequencer_inst (
        .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_drive_n(sda_drive_n), .cfg(cfg),
        .int_pin_asserted(int_pin), .engine_done(engine_done),
        .led_request(led_request), .engine_run(engine_run),
        .led_drive_pin(led_drive_pin), .osc_enable(osc_enable),
        .exit_pause(exit_pause), .sai_sleeping(sai_sleeping),
        .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_addr(rd_addr), .rd_data(rd_data), .int_clear(int_clear));
    oss_i2c_host oss_i2c_host_inst (.clock(clock), .scl(scl),
        .sda_host(sda_host), .sda_wire(sda_wire));

    initial clock = 1'b0;
    always #2 clock = ~clock;

    // engines finish five cycles after entry
    always @(negedge clock) begin
        run_cnt = (engine_run != last_run) ? 0 : run_cnt + 1;
        last_run = engine_run;
        engine_done <= (run_cnt == 4) ? engine_run : '0;
    end

    always @(negedge clock) begin
        if (wr_strobe) wr_q.push_back({wr_addr, wr_data});
        if (int_clear) clr_cnt++;
        if (led_drive_pin) led_cnt++;
        if (exit_pause) pause_seen = 1'b1;
        if (engine_run != '0 && engine_run != prev_run) begin
            seq_q.push_back(engine_run);
        end
        if (engine_run.als && !prev_run.als) als_gap = gap;
        gap = (engine_run == '0) ? gap + 1 : 0;
        prev_run = engine_run;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 4000) begin
            errors++;
            $display("CHECK FAILED %0t wait expired", $time);
            summarize();
        end
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic       a;
        oss_i2c_host_inst.xfer(d, 1'b1, q, a);
        chk(a, exp_ack, "acknowledge slot");
    endtask
    task automatic recv(input logic [7:0] exp, input logic last);
        logic [7:0] q;
        logic       a;
        oss_i2c_host_inst.xfer(8'hff, last, q, a);
        chk(q, exp, "read data");
    endtask
    task automatic pop_wr(input logic [12:0] exp);
        chk(wr_q.size() > 0, 1, "missing write");
        if (wr_q.size() > 0) chk(wr_q.pop_front(), exp, "write");
    endtask
    task automatic cycle(input oss_cfg_t c, input logic [8:0] exp,
                         input int lo, input int hi);
        int n;
        cfg.power_on = 1'b0;
        repeat (4) @(negedge clock);
        chk(engine_run, 3'h0, "engine with power off");
        seq_q.delete();
        pause_seen = 1'b0;
        cfg = c;
        for (n = 0; n < 4000 && seq_q.size() < 3; n++) @(negedge clock);
        bound(n);
        chk(pause_seen, 1, "exit pause");
        chk({seq_q[0], seq_q[1], seq_q[2]}, exp, "engine order");
        chk(als_gap >= lo && als_gap <= hi, 1, "wait length");
        $display("test engine cycle done");
    endtask

    initial begin
        int n;
        rst = 1'b1;
        cfg = '0;
        int_pin = 1'b0;
        led_request = 1'b1;
        engine_done = '0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        chk({osc_enable, engine_run, sda_drive_n}, 5'h01, "reset");
        oss_i2c_host_inst.start();
        send(8'h72, 1'b0);
        chk(osc_enable, 1, "bus wake");
        send(8'h85, 1'b0);
        send(8'ha5, 1'b0);
        send(8'h3c, 1'b0);
        oss_i2c_host_inst.stop();
        oss_i2c_host_inst.start();
        send(8'h72, 1'b0);
        send(8'h11, 1'b0);
        oss_i2c_host_inst.stop();
        pop_wr({5'h05, 8'ha5});
        pop_wr({5'h06, 8'h3c});
        pop_wr({5'h05, 8'h11});
        oss_i2c_host_inst.start();
        send(8'h70, 1'b1);
        send(8'h99, 1'b1);
        oss_i2c_host_inst.stop();
        chk(wr_q.size(), 0, "foreign write stored");
        oss_i2c_host_inst.start();
        send(8'h72, 1'b0);
        send(8'h8a, 1'b0);
        oss_i2c_host_inst.start();
        send(8'h73, 1'b0);
        recv(8'h4a, 1'b0);
        recv(8'h4b, 1'b1);
        oss_i2c_host_inst.stop();
        oss_i2c_host_inst.start();
        send(8'h73, 1'b0);
        recv(8'h4a, 1'b1);
        oss_i2c_host_inst.stop();
        oss_i2c_host_inst.start();
        send(8'h72, 1'b0);
        send(8'he0, 1'b0);
        oss_i2c_host_inst.stop();
        chk(clr_cnt, 1, "control command");
        $display("test bus done");
        cycle('{1, 1, 1, 1, 1, 1, 0, 0, 8'hfe}, 9'h111, 6, 14);
        chk(led_cnt > 0, 1, "led in proximity");
        cycle('{1, 1, 1, 0, 1, 1, 1, 0, 8'hfe}, 9'h10c, 94, 104);
        cfg.sleep_after_interrupt = 1'b1;
        int_pin = 1'b1;
        for (n = 0; n < 4000 && sai_sleeping !== 1'b1; n++) @(negedge clock);
        bound(n);
        repeat (20) @(negedge clock);
        chk({sai_sleeping, engine_run}, 4'h8, "sleep after irq");
        cfg.sleep_after_interrupt = 1'b0;
        repeat (4) @(negedge clock);
        chk(sai_sleeping, 0, "leave on bit clear");
        cfg.sleep_after_interrupt = 1'b1;
        for (n = 0; n < 4000 && sai_sleeping !== 1'b1; n++) @(negedge clock);
        bound(n);
        int_pin = 1'b0;
        oss_i2c_host_inst.start();
        send(8'h72, 1'b0);
        send(8'he0, 1'b0);
        oss_i2c_host_inst.stop();
        chk(sai_sleeping, 0, "leave on bus clear");
        $display("test sleep after interrupt done");
        summarize();
    end
endmodule
